// ==== hw/dtc_consts.svh ====
// offsets, field positions, reset values and timing counts of the dual timer block
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// register indices; the byte address on the bus is four times the index
`define DTC_IDX_TCTL      10'h088
`define DTC_IDX_TMODE     10'h089
`define DTC_IDX_T0_LOW    10'h08a
`define DTC_IDX_T1_LOW    10'h08b
`define DTC_IDX_T0_HIGH   10'h08c
`define DTC_IDX_T1_HIGH   10'h08d
// control/flag register bit positions
`define DTC_TCTL_T1_OVF   7
`define DTC_TCTL_T1_RUN   6
`define DTC_TCTL_T0_OVF   5
`define DTC_TCTL_T0_RUN   4
`define DTC_TCTL_X1_PEND  3
`define DTC_TCTL_X1_TYPE  2
`define DTC_TCTL_X0_PEND  1
`define DTC_TCTL_X0_TYPE  0
// mode register: timer 1 nibble, timer 0 nibble, fields inside a nibble
`define DTC_TMODE_T1_BASE 4
`define DTC_TMODE_T0_BASE 0
`define DTC_TMODE_GATE    3
`define DTC_TMODE_CNT_SEL 2
`define DTC_TMODE_MODE_HI 1
`define DTC_TMODE_MODE_LO 0
// reset values
`define DTC_RST_BYTE      8'h00
`define DTC_RST_PIN_SHR   3'h7
// machine cycle tick: cpu clocks per prescaled tick
`define DTC_TICK_DIV      12
`endif

// ==== hw/dtc_pkg.sv ====
// types shared by the dual timer/counter modules
package dtc_pkg;
    // operating mode as encoded in the two-bit mode field
    typedef enum logic [1:0] {DTC_MODE0, DTC_MODE1, DTC_MODE2, DTC_MODE3} dtc_mode_type;

    // pin filter state
    typedef struct packed {
        logic [2:0] shr;
        logic       level;
        logic       fall;
    } dtc_sync_state_type;

    // external interrupt flag state
    typedef struct packed {
        logic pending;
    } dtc_xirq_state_type;

    // state held in the timer core itself; pin filters and pending flags live in their own modules
    typedef struct packed {
        logic [7:0]  tmode;
        logic [7:0]  t0_low;
        logic [7:0]  t0_high;
        logic [7:0]  t1_low;
        logic [7:0]  t1_high;
        logic        t1_ovf;
        logic        t1_run;
        logic        t0_ovf;
        logic        t0_run;
        logic        x1_type;
        logic        x0_type;
        logic [7:0]  presc;
        logic [31:0] prdata;
    } dtc_core_state_type;
endpackage

// ==== hw/dtc_pin_if.sv ====
// filtered pin level and falling-edge pulse between pin filter and its users
`timescale 1ns/100ps
`default_nettype none
interface dtc_pin_if;
    logic level;
    logic fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface
`default_nettype wire

// ==== hw/dtc_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter and fall detect
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_pin_sync
    import dtc_pkg::*;
(
    input  wire logic  i_mclk,   // core clock
    input  wire logic  i_rst_n,  // async reset, active low
    input  wire logic  i_ce,     // clock enable
    input  wire logic  i_pin,    // raw pin
    dtc_pin_if.src     pin_bus   // filtered level and fall pulse
);
    dtc_sync_state_type s_reg;
    dtc_sync_state_type s_next;

    // level only moves once stages two and three agree; stage one feeds stage two only
    always_comb
    begin
        s_next       = s_reg;
        s_next.shr   = {s_reg.shr[1:0], i_pin};
        s_next.fall  = 1'b0;
        if (s_reg.shr[1] == s_reg.shr[2])
        begin
            s_next.level = s_reg.shr[2];
            s_next.fall  = s_reg.level & ~s_reg.shr[2];
        end
    end

    // idle pins are high, so reset assumes high
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_reg.shr   <= `DTC_RST_PIN_SHR;
            s_reg.level <= 1'b1;
            s_reg.fall  <= 1'b0;
        end
        else if (i_ce)
        begin
            s_reg <= s_next;
        end
    end

    assign pin_bus.level = s_reg.level;
    assign pin_bus.fall  = s_reg.fall;
endmodule
`default_nettype wire

// ==== hw/dtc_xirq.sv ====
// external interrupt pending flag with edge or level trigger
`timescale 1ns/100ps
`default_nettype none
module dtc_xirq
    import dtc_pkg::*;
(
    input  wire logic  i_mclk,         // core clock
    input  wire logic  i_rst_n,        // async reset, active low
    input  wire logic  i_ce,           // clock enable
    dtc_pin_if.dst     pin_bus,        // filtered interrupt pin
    input  wire logic  i_trigger_edge, // 1 falling edge, 0 low level
    input  wire logic  i_reti,         // return-from-interrupt pulse
    output logic       o_pending       // pending flag
);
    dtc_xirq_state_type s_reg;
    dtc_xirq_state_type s_next;
    logic               detect;

    // detection wins over the clear so an event in the clear cycle is kept
    always_comb
    begin
        detect = i_trigger_edge ? pin_bus.fall : ~pin_bus.level;
        s_next = s_reg;
        if (detect)
        begin
            s_next.pending = 1'b1;
        end
        else if (i_reti)
        begin
            s_next.pending = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_reg.pending <= 1'b0;
        end
        else if (i_ce)
        begin
            s_reg <= s_next;
        end
    end

    assign o_pending = s_reg.pending;
endmodule
`default_nettype wire

// ==== hw/dtc_timer_core.sv ====
// dual timer/counter control with apb register access
`timescale 1ns/100ps
`default_nettype none
// register offsets, field positions and the tick count
`include "dtc_consts.svh"
module dtc_timer_core
    import dtc_pkg::*;
#(
    parameter int TICK_DIV = `DTC_TICK_DIV  // cpu clocks per machine tick
)
(
    input  wire logic        i_mclk,            // core clock, 100 MHz
    input  wire logic        i_rst_n,           // async reset, active low
    input  wire logic        i_ce,              // clock enable, freezes all state
    input  wire logic        i_psel,            // apb select
    input  wire logic        i_penable,         // apb enable
    input  wire logic        i_pwrite,          // apb write
    input  wire logic [11:0] i_paddr,           // apb byte address
    input  wire logic [31:0] i_pwdata,          // apb write data
    input  wire logic [3:0]  i_pstrb,           // apb byte strobes
    output logic      [31:0] o_prdata,          // apb read data
    output logic             o_pready,          // apb ready
    output logic             o_pslverr,         // apb error on unmapped address
    input  wire logic        i_ext_irq0_pin,    // external interrupt 0 pin
    input  wire logic        i_ext_irq1_pin,    // external interrupt 1 pin
    input  wire logic        i_t0_count_pin,    // timer 0 event pin
    input  wire logic        i_t1_count_pin,    // timer 1 event pin
    input  wire logic        i_t0_vector_ack,   // cpu vectors to timer 0 routine
    input  wire logic        i_t1_vector_ack,   // cpu vectors to timer 1 routine
    input  wire logic        i_ext0_reti,       // return from ext 0 routine
    input  wire logic        i_ext1_reti,       // return from ext 1 routine
    output logic             o_t0_irq,          // timer 0 interrupt request
    output logic             o_t1_irq,          // timer 1 interrupt request
    output logic             o_ext0_irq,        // external 0 interrupt request
    output logic             o_ext1_irq         // external 1 interrupt request
);
    localparam logic [7:0] PRESC_LAST = 8'(TICK_DIV - 1);

    // state comes first: the interrupt instances below read its type bits
    dtc_core_state_type s_reg;
    dtc_core_state_type s_next;

    ////////////////////////////////////////////////////////////////////////////
    // pin filters and external interrupt flags

    dtc_pin_if x0_bus ();
    dtc_pin_if x1_bus ();
    dtc_pin_if c0_bus ();
    dtc_pin_if c1_bus ();

    logic x0_pending;
    logic x1_pending;

    dtc_pin_sync u_sync_x0 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
                            .i_pin(i_ext_irq0_pin), .pin_bus(x0_bus));
    dtc_pin_sync u_sync_x1 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
                            .i_pin(i_ext_irq1_pin), .pin_bus(x1_bus));
    dtc_pin_sync u_sync_c0 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
                            .i_pin(i_t0_count_pin), .pin_bus(c0_bus));
    dtc_pin_sync u_sync_c1 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
                            .i_pin(i_t1_count_pin), .pin_bus(c1_bus));

    // flags live in the small modules; the type bits come from here
    dtc_xirq u_xirq0 (
        .i_mclk         (i_mclk),
        .i_rst_n        (i_rst_n),
        .i_ce           (i_ce),
        .pin_bus        (x0_bus),
        .i_trigger_edge (s_reg.x0_type),
        .i_reti         (i_ext0_reti),
        .o_pending      (x0_pending)
    );
    dtc_xirq u_xirq1 (
        .i_mclk         (i_mclk),
        .i_rst_n        (i_rst_n),
        .i_ce           (i_ce),
        .pin_bus        (x1_bus),
        .i_trigger_edge (s_reg.x1_type),
        .i_reti         (i_ext1_reti),
        .o_pending      (x1_pending)
    );

    ////////////////////////////////////////////////////////////////////////////
    // one count step of a timer: returns {overflow, high, low}

    function automatic logic [16:0] dtc_step(
        input dtc_mode_type m,
        input logic [7:0]   hi,
        input logic [7:0]   lo,
        input logic         inc
    );
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        logic [16:0] r;
        begin
            c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            c16 = {1'b0, hi, lo} + 17'h00001;
            c8  = {1'b0, lo} + 9'h001;
            r   = {1'b0, hi, lo};
            if (inc)
            begin
                unique case (m)
                    // upper three low bits are left untouched
                    DTC_MODE0: r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
                    DTC_MODE1: r = c16;
                    // reload keeps the high byte, only software changes it
                    DTC_MODE2: r = {c8[8], hi, c8[8] ? hi : c8[7:0]};
                    DTC_MODE3: r = {c8[8], hi, c8[7:0]};
                endcase
            end
            return r;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state and decode

    dtc_mode_type t0_mode;
    dtc_mode_type t1_mode;
    logic         t0_gate;
    logic         t1_gate;
    logic         t0_cnt_sel;
    logic         t1_cnt_sel;
    logic         tick;
    logic         t0_en;
    logic         t1_en;
    logic         t0_inc;
    logic         t1_inc;
    logic         t0h_inc;
    logic [16:0]  t0_res;
    logic [16:0]  t1_res;
    logic [8:0]   t0h_sum;
    logic         t0_wrap;
    logic         t1_wrap;
    logic         hit_tctl;
    logic         hit_tmode;
    logic         hit_t0l;
    logic         hit_t0h;
    logic         hit_t1l;
    logic         hit_t1h;
    logic         mapped;
    logic         access;
    logic         wr_en;
    logic [7:0]   wbyte;
    logic [7:0]   tctl_view;
    logic [7:0]   rd_byte;

    // mode register fields
    always_comb
    begin
        t1_gate    = s_reg.tmode[`DTC_TMODE_T1_BASE + `DTC_TMODE_GATE];
        t1_cnt_sel = s_reg.tmode[`DTC_TMODE_T1_BASE + `DTC_TMODE_CNT_SEL];
        t1_mode    = dtc_mode_type'(s_reg.tmode[`DTC_TMODE_T1_BASE +: 2]);
        t0_gate    = s_reg.tmode[`DTC_TMODE_T0_BASE + `DTC_TMODE_GATE];
        t0_cnt_sel = s_reg.tmode[`DTC_TMODE_T0_BASE + `DTC_TMODE_CNT_SEL];
        t0_mode    = dtc_mode_type'(s_reg.tmode[`DTC_TMODE_T0_BASE +: 2]);
    end

    // address decode: one aligned word per register
    always_comb
    begin
        hit_tctl  = (i_paddr[11:2] == `DTC_IDX_TCTL);
        hit_tmode = (i_paddr[11:2] == `DTC_IDX_TMODE);
        hit_t0l   = (i_paddr[11:2] == `DTC_IDX_T0_LOW);
        hit_t0h   = (i_paddr[11:2] == `DTC_IDX_T0_HIGH);
        hit_t1l   = (i_paddr[11:2] == `DTC_IDX_T1_LOW);
        hit_t1h   = (i_paddr[11:2] == `DTC_IDX_T1_HIGH);
        mapped    = hit_tctl | hit_tmode | hit_t0l | hit_t0h | hit_t1l | hit_t1h;
        access    = i_psel & i_penable & i_ce;
        // only byte lane 0 carries data; other lanes are ignored
        wr_en     = access & i_pwrite & mapped & i_pstrb[0];
        wbyte     = i_pwdata[7:0];
    end

    // readable control view; pending flags come from the interrupt modules
    always_comb
    begin
        tctl_view                    = 8'h00;
        tctl_view[`DTC_TCTL_T1_OVF]  = s_reg.t1_ovf;
        tctl_view[`DTC_TCTL_T1_RUN]  = s_reg.t1_run;
        tctl_view[`DTC_TCTL_T0_OVF]  = s_reg.t0_ovf;
        tctl_view[`DTC_TCTL_T0_RUN]  = s_reg.t0_run;
        tctl_view[`DTC_TCTL_X1_PEND] = x1_pending;
        tctl_view[`DTC_TCTL_X1_TYPE] = s_reg.x1_type;
        tctl_view[`DTC_TCTL_X0_PEND] = x0_pending;
        tctl_view[`DTC_TCTL_X0_TYPE] = s_reg.x0_type;
        unique case (1'b1)
            hit_tctl:  rd_byte = tctl_view;
            hit_tmode: rd_byte = s_reg.tmode;
            hit_t0l:   rd_byte = s_reg.t0_low;
            hit_t0h:   rd_byte = s_reg.t0_high;
            hit_t1l:   rd_byte = s_reg.t1_low;
            hit_t1h:   rd_byte = s_reg.t1_high;
            default:   rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // count enables and count steps

    always_comb
    begin
        tick    = (s_reg.presc == PRESC_LAST);
        // gate pin is the filtered level, so a glitch cannot open the gate
        t0_en   = s_reg.t0_run & (~t0_gate | x0_bus.level);
        t1_en   = s_reg.t1_run & (~t1_gate | x1_bus.level)
                  & (t1_mode != DTC_MODE3);
        t0_inc  = t0_en & (t0_cnt_sel ? c0_bus.fall : tick);
        t1_inc  = t1_en & (t1_cnt_sel ? c1_bus.fall : tick);
        // split timer 0 high byte counts machine ticks on timer 1's run bit
        t0h_inc = (t0_mode == DTC_MODE3) & s_reg.t1_run & tick;
        t0_res  = dtc_step(t0_mode, s_reg.t0_high, s_reg.t0_low, t0_inc);
        t1_res  = dtc_step(t1_mode, s_reg.t1_high, s_reg.t1_low, t1_inc);
        t0h_sum = {1'b0, s_reg.t0_high} + 9'h001;
        t0_wrap = t0_res[16];
        // timer 1 loses its flag to the split high byte in mode 3
        t1_wrap = (t0_mode == DTC_MODE3) ? (t0h_inc & t0h_sum[8]) : t1_res[16];
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: software write beats counting, hardware set beats any clear

    always_comb
    begin
        s_next         = s_reg;
        s_next.presc   = tick ? 8'h00 : s_reg.presc + 8'h01;
        s_next.t0_low  = t0_res[7:0];
        s_next.t0_high = t0h_inc ? t0h_sum[7:0] : t0_res[15:8];
        s_next.t1_low  = t1_res[7:0];
        s_next.t1_high = t1_res[15:8];
        if (i_t0_vector_ack)
        begin
            s_next.t0_ovf = 1'b0;
        end
        if (i_t1_vector_ack)
        begin
            s_next.t1_ovf = 1'b0;
        end
        if (wr_en)
        begin
            unique case (1'b1)
                hit_tctl:
                begin
                    // pending bits are read-only here; only interrupt return clears them
                    s_next.t1_ovf  = wbyte[`DTC_TCTL_T1_OVF];
                    s_next.t1_run  = wbyte[`DTC_TCTL_T1_RUN];
                    s_next.t0_ovf  = wbyte[`DTC_TCTL_T0_OVF];
                    s_next.t0_run  = wbyte[`DTC_TCTL_T0_RUN];
                    s_next.x1_type = wbyte[`DTC_TCTL_X1_TYPE];
                    s_next.x0_type = wbyte[`DTC_TCTL_X0_TYPE];
                end
                hit_tmode: s_next.tmode   = wbyte;
                hit_t0l:   s_next.t0_low  = wbyte;
                hit_t0h:   s_next.t0_high = wbyte;
                hit_t1l:   s_next.t1_low  = wbyte;
                hit_t1h:   s_next.t1_high = wbyte;
                default:   s_next.tmode   = s_reg.tmode;
            endcase
        end
        if (t0_wrap)
        begin
            s_next.t0_ovf = 1'b1;
        end
        if (t1_wrap)
        begin
            s_next.t1_ovf = 1'b1;
        end
        // read data captured in the setup cycle, shown in the access cycle
        if (i_psel & ~i_penable)
        begin
            s_next.prdata = {24'h000000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_reg.tmode   <= `DTC_RST_BYTE;
            s_reg.t0_low  <= `DTC_RST_BYTE;
            s_reg.t0_high <= `DTC_RST_BYTE;
            s_reg.t1_low  <= `DTC_RST_BYTE;
            s_reg.t1_high <= `DTC_RST_BYTE;
            s_reg.t1_ovf  <= 1'b0;
            s_reg.t1_run  <= 1'b0;
            s_reg.t0_ovf  <= 1'b0;
            s_reg.t0_run  <= 1'b0;
            s_reg.x1_type <= 1'b0;
            s_reg.x0_type <= 1'b0;
            s_reg.presc   <= 8'h00;
            s_reg.prdata  <= 32'h00000000;
        end
        else if (i_ce)
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states; ready drops while frozen so no transfer is lost
    assign o_pready   = i_ce;
    assign o_pslverr  = i_psel & i_penable & ~mapped;
    assign o_prdata   = s_reg.prdata;
    // requests follow the flags for as long as they stay set
    assign o_t0_irq   = s_reg.t0_ovf;
    assign o_t1_irq   = s_reg.t1_ovf;
    assign o_ext0_irq = x0_pending;
    assign o_ext1_irq = x1_pending;
endmodule
`default_nettype wire

// ==== bench/dtc_core_properties.sv ====
// port assertions for the dual timer block
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_core_props
    import dtc_pkg::*;
#(
    parameter int TICK_DIV = 12  // cpu clocks per tick
)
(
    input wire logic        i_mclk,          // clock
    input wire logic        i_rst_n,         // reset
    input wire logic        i_ce,            // enable
    input wire logic        i_psel,          // select
    input wire logic        i_penable,       // enable phase
    input wire logic        i_pwrite,        // write
    input wire logic [11:0] i_paddr,         // address
    input wire logic [31:0] i_pwdata,        // write data
    input wire logic [3:0]  i_pstrb,         // strobes
    input wire logic [31:0] o_prdata,        // read data
    input wire logic        o_pready,        // ready
    input wire logic        o_pslverr,       // error
    input wire logic        i_ext_irq0_pin,  // ext pin 0
    input wire logic        i_ext_irq1_pin,  // ext pin 1
    input wire logic        i_t0_count_pin,  // event pin 0
    input wire logic        i_t1_count_pin,  // event pin 1
    input wire logic        i_t0_vector_ack, // vector 0
    input wire logic        i_t1_vector_ack, // vector 1
    input wire logic        i_ext0_reti,     // return 0
    input wire logic        i_ext1_reti,     // return 1
    input wire logic        o_t0_irq,        // timer 0 request
    input wire logic        o_t1_irq,        // timer 1 request
    input wire logic        o_ext0_irq,      // ext 0 request
    input wire logic        o_ext1_irq       // ext 1 request
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////
    // decode helpers; a control write may legally clear a flag
    logic acc;
    logic mapped;
    logic ctl_wr;
    assign acc = i_psel && i_penable && i_ce;
    assign mapped = i_paddr[11:2] >= `DTC_IDX_TCTL && i_paddr[11:2] <= `DTC_IDX_T1_HIGH;
    assign ctl_wr = acc && i_pwrite && i_pstrb[0] && i_paddr[11:2] == `DTC_IDX_TCTL;
    ////////////////////////////////////////////////////////////////////////
    AST_READY: assert property (i_psel && i_penable |-> o_pready == i_ce)
        else $error("ready not following enable");
    AST_SLVERR: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
        else $error("error flag wrong for address");
    AST_ERR_DATA: assert property (acc && !mapped && !i_pwrite |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RD_UPPER: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_T1_HOLD: assert property (o_t1_irq && !i_t1_vector_ack && !ctl_wr |=> o_t1_irq)
        else $error("timer 1 flag lost without clear");
    AST_T0_HOLD: assert property (o_t0_irq && !i_t0_vector_ack && !ctl_wr |=> o_t0_irq)
        else $error("timer 0 flag lost without clear");
    AST_X1_HOLD: assert property (o_ext1_irq && !i_ext1_reti |=> o_ext1_irq)
        else $error("ext 1 flag lost without return");
    AST_X0_QUIET: assert property ((i_ext_irq0_pin && !o_ext0_irq)[*6] |=> !o_ext0_irq)
        else $error("ext 0 flag set with pin high");
endmodule
bind dtc_timer_core dtc_core_props #(.TICK_DIV(TICK_DIV)) dtc_core_props_i (.*);
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the dual timer block
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module tb_top;
    import dtc_pkg::*;
    localparam logic [11:0] A_CTL = {`DTC_IDX_TCTL, 2'b00};
    localparam logic [11:0] A_MOD = {`DTC_IDX_TMODE, 2'b00};
    localparam logic [11:0] A_T0L = {`DTC_IDX_T0_LOW, 2'b00};
    localparam logic [11:0] A_T1L = {`DTC_IDX_T1_LOW, 2'b00};
    localparam logic [11:0] A_T1H = {`DTC_IDX_T1_HIGH, 2'b00};
    localparam logic [11:0] A_T0H = {`DTC_IDX_T0_HIGH, 2'b00};
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        p0 = 1'b1, p1 = 1'b1, c0 = 1'b1, c1 = 1'b1, ce = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rq;
    logic [3:0]  ack = 4'h0;  // vector 0, vector 1, return 0, return 1
    wire  logic [31:0] prdata;
    wire  logic        pready, pslverr;
    wire  logic [3:0]  irq;
    int          error_cnt = 0, samples_checked = 0, cyc = 0;
    dtc_timer_core #(.TICK_DIV(2)) dtc_timer_core_i (.i_mclk(clk), .i_rst_n(rst_n),
        .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_ext_irq0_pin(p0), .i_ext_irq1_pin(p1), .i_t0_count_pin(c0),
        .i_t1_count_pin(c1), .i_t0_vector_ack(ack[0]), .i_t1_vector_ack(ack[1]),
        .i_ext0_reti(ack[2]), .i_ext1_reti(ack[3]), .o_t0_irq(irq[0]), .o_t1_irq(irq[1]),
        .o_ext0_irq(irq[2]), .o_ext1_irq(irq[3]));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt = error_cnt + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer; idle edge first so strobes never toggle twice at once
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rq = prdata;
        chk("slverr", pslverr, a[11:2] > `DTC_IDX_T1_HIGH);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        ack[k] <= 1'b1;
        @(posedge clk);
        ack[k] <= 1'b0;
        @(posedge clk);
        chk("flag clear", irq[k], 1'b0);
    endtask
    task automatic wait_hi(input int k);
        int n;
        for (n = 0; n < 80 && irq[k] !== 1'b1; n++)
            @(posedge clk);
        chk("request", irq[k], 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // all six registers clear after reset, then an unmapped word
        for (int k = 0; k < 6; k++)
        begin
            xfer(1'b0, A_CTL + 12'(4 * k), 8'h00);
            chk("reset value", rq, 32'h0);
        end
        xfer(1'b0, 12'h3fc, 8'h00);
        chk("unmapped", rq, 32'h0);
        xfer(1'b1, A_MOD, 8'ha5);
        xfer(1'b0, A_MOD, 8'h00);
        chk("mode", rq, 32'ha5);
        // pending bits read only, pins idle so nothing pending
        xfer(1'b1, A_CTL, 8'h0f);
        xfer(1'b0, A_CTL, 8'h00);
        chk("control", rq, 32'h05);
        // 16-bit wrap, stop keeps the flag, vectoring clears it
        xfer(1'b1, A_MOD, 8'h01);
        xfer(1'b1, A_T0H, 8'hff);
        xfer(1'b1, A_T0L, 8'hfe);
        xfer(1'b1, A_CTL, 8'h15);
        wait_hi(0);
        xfer(1'b1, A_CTL, 8'h25);
        xfer(1'b0, A_T0H, 8'h00);
        chk("t0 high", rq, 32'h0);
        chk("t0 kept", irq[0], 1'b1);
        pulse(0);
        // 13-bit wrap: top three low bits not counted
        xfer(1'b1, A_MOD, 8'h00);
        xfer(1'b1, A_T0L, 8'hff);
        xfer(1'b1, A_T0H, 8'hff);
        xfer(1'b1, A_CTL, 8'h15);
        wait_hi(0);
        xfer(1'b1, A_CTL, 8'h05);
        xfer(1'b0, A_T0H, 8'h00);
        chk("t0 high", rq, 32'h0);
        xfer(1'b0, A_T0L, 8'h00);
        chk("t0 low top", rq[7:5], 3'b111);
        chk("sw clear", irq[0], 1'b0);
        // 8-bit reload of timer 1, software clear of its flag
        xfer(1'b1, A_MOD, 8'h20);
        xfer(1'b1, A_T1H, 8'h80);
        xfer(1'b1, A_T1L, 8'hff);
        xfer(1'b1, A_CTL, 8'h45);
        wait_hi(1);
        xfer(1'b1, A_CTL, 8'h05);
        xfer(1'b0, A_T1H, 8'h00);
        chk("t1 high", rq, 32'h80);
        xfer(1'b0, A_T1L, 8'h00);
        chk("t1 reload", rq[7:4], 4'h8);
        chk("t1 clear", irq[1], 1'b0);
        // gate closed by low pin; timer 1 parked; timer 0 split in mode 3; ext 0 fall
        xfer(1'b1, A_T0L, 8'h00);
        xfer(1'b1, A_T1L, 8'h00);
        xfer(1'b1, A_MOD, 8'h3b);
        p0 <= 1'b0;
        wait_hi(2);
        xfer(1'b1, A_CTL, 8'h55);
        repeat (20) @(posedge clk);
        xfer(1'b0, A_T0L, 8'h00);
        chk("gated", rq, 32'h0);
        xfer(1'b0, A_T1L, 8'h00);
        chk("t1 stopped", rq, 32'h0);
        xfer(1'b0, A_T0H, 8'h00);
        chk("split high", rq[7:0] != 8'h00, 1'b1);
        pulse(2);
        p0 <= 1'b1;
        repeat (20) @(posedge clk);
        xfer(1'b0, A_T0L, 8'h00);
        chk("gate open", rq[7:0] != 8'h00, 1'b1);
        // event counting: three falls on the count pin
        xfer(1'b1, A_CTL, 8'h05);
        xfer(1'b1, A_MOD, 8'h05);
        xfer(1'b1, A_T0L, 8'h00);
        xfer(1'b1, A_CTL, 8'h15);
        for (int k = 0; k < 6; k++)
        begin
            repeat (6) @(posedge clk);
            c0 <= k[0];
        end
        xfer(1'b0, A_T0L, 8'h00);
        chk("events", rq, 32'h3);
        // low-level trigger on ext 1, cleared on return once pin is high
        xfer(1'b1, A_CTL, 8'h01);
        ce <= 1'b0;
        p1 <= 1'b0;
        // a frozen block must not see the pin go low
        repeat (8) @(posedge clk);
        chk("frozen", irq[3], 1'b0);
        ce <= 1'b1;
        wait_hi(3);
        p1 <= 1'b1;
        repeat (8) @(posedge clk);
        pulse(3);
        stop_test();
    end
endmodule
`default_nettype wire
